// ==== inc/ddt_cfg.svh ====
// offsets, field positions, reset values and widths of the timer pair
// assumes inclusion by bare name from the design file
`ifndef DDT_CFG_SVH
`define DDT_CFG_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define DDT_IDX_T1_HIGH  16'h1010
`define DDT_IDX_T1_LOW   16'h1011
`define DDT_IDX_T1_CTL   16'h1012
`define DDT_IDX_T2_HIGH  16'h1013
`define DDT_IDX_T2_LOW   16'h1014
`define DDT_IDX_T2_CTL   16'h1015
`define DDT_IDX_INT_STAT 16'h1020
`define DDT_IDX_INT_MASK 16'h1021

// ==========================================================
// fields and reset values
`define DDT_CTL_RESET    8'h00
`define DDT_INT_T1_BIT   4
`define DDT_INT_T2_BIT   5
`define DDT_CNT_W        12
`define DDT_PRE_W        16
`define DDT_CNT_ONE      12'h001

// ==========================================================
// prescaler division exponents
`define DDT_SHIFT_16     16
`define DDT_SHIFT_14     14
`define DDT_SHIFT_10     10
`define DDT_SHIFT_6      6
`define DDT_SHIFT_2      2

`endif

// ==== inc/ddt_pkg.sv ====
// types shared by the timer pair
// assumes nothing beyond a SystemVerilog compiler
package ddt_pkg;

    // ==========================================================
    // count clock selection
    typedef enum logic [2:0] {
        DDT_SRC_PIN   = 3'b000,
        DDT_SRC_DIV16 = 3'b001,
        DDT_SRC_DIV14 = 3'b010,
        DDT_SRC_DIV10 = 3'b011,
        DDT_SRC_DIV6  = 3'b100,
        DDT_SRC_DIV2  = 3'b101,
        DDT_SRC_32K   = 3'b110,
        DDT_SRC_ALT   = 3'b111
    } ddt_src_t;

    // ==========================================================
    // control register layout
    typedef struct packed {
        logic     enable;
        logic     wake;
        logic     wake_rst;
        logic     rsvd;
        logic     loop;
        ddt_src_t src;
    } ddt_ctl_t;

endpackage : ddt_pkg

// ==== rtl/ddt_timers.sv ====
// two 12-bit down-count timers with apb registers and interrupt
// assumes apb master on pclk; pins and slow clocks are asynchronous
`include "ddt_cfg.svh"

module ddt_timers
    import ddt_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // count clock sources, asynchronous
    input  wire logic        external_port_pin_zero,
    input  wire logic        external_port_pin_one,
    input  wire logic        user_divided_clock,
    input  wire logic        clk_32768,
    // events
    output logic             irq,
    output logic             wakeup,
    output logic             wake_reset_req,
    output logic             timer_one_out
);

    // ==========================================================
    // helpers
    function automatic logic ddt_hit(input logic [31:0] a,
                                     input logic [15:0] idx);
        ddt_hit = (a == {14'h0000, idx, 2'b00});
    endfunction : ddt_hit

    function automatic logic ddt_tick(input ddt_src_t s,
                                      input logic pin_e,
                                      input logic usr_e,
                                      input logic [15:0] p,
                                      input logic k_e,
                                      input logic alt);
        logic r;
        r = 1'b0;
        unique case (s)
            DDT_SRC_PIN:   r = pin_e;
            DDT_SRC_DIV16: r = usr_e & (&p[`DDT_SHIFT_16-1:0]);
            DDT_SRC_DIV14: r = usr_e & (&p[`DDT_SHIFT_14-1:0]);
            DDT_SRC_DIV10: r = usr_e & (&p[`DDT_SHIFT_10-1:0]);
            DDT_SRC_DIV6:  r = usr_e & (&p[`DDT_SHIFT_6-1:0]);
            DDT_SRC_DIV2:  r = usr_e & (&p[`DDT_SHIFT_2-1:0]);
            DDT_SRC_32K:   r = k_e;
            DDT_SRC_ALT:   r = alt;
        endcase
        ddt_tick = r;
    endfunction : ddt_tick

    localparam logic [15:0] IDX_HI  [2] = '{`DDT_IDX_T1_HIGH,
                                            `DDT_IDX_T2_HIGH};
    localparam logic [15:0] IDX_LO  [2] = '{`DDT_IDX_T1_LOW,
                                            `DDT_IDX_T2_LOW};
    localparam logic [15:0] IDX_CTL [2] = '{`DDT_IDX_T1_CTL,
                                            `DDT_IDX_T2_CTL};

    // ==========================================================
    // synchronisers: stage a feeds stage b only
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [3:0] sync_c;
    logic [3:0] rise;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
            sync_c <= 4'h0;
        end
        else
        begin
            sync_a <= {clk_32768, user_divided_clock,
                       external_port_pin_one, external_port_pin_zero};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    assign rise = sync_b & ~sync_c;

    // ==========================================================
    // prescaler on user divided clock edges
    logic [`DDT_PRE_W-1:0] presc;
    logic [`DDT_PRE_W-1:0] next_presc;

    always_comb
    begin
        next_presc = presc;
        if (rise[2])
            next_presc = presc + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            presc <= 16'h0000;
        else
            presc <= next_presc;
    end

    // ==========================================================
    // apb decode
    logic wr_en;
    logic rd_setup;

    assign wr_en    = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign pready   = 1'b1;

    // ==========================================================
    // timers
    ddt_ctl_t [1:0]                  ctl_a;
    logic     [1:0][`DDT_CNT_W-1:0]  reload_a;
    logic     [1:0][`DDT_CNT_W-1:0]  cnt_a;
    logic     [1:0]                  tick;
    logic     [1:0]                  expire;

    // timer one source 111 is ground; timer two's is timer one expiry
    assign tick[0] = ddt_tick(ctl_a[0].src, rise[0], rise[2], presc,
                              rise[3], 1'b0);
    assign tick[1] = ddt_tick(ctl_a[1].src, rise[1], rise[2], presc,
                              rise[3], expire[0]);

    for (genvar i = 0; i < 2; i++)
    begin : g_tmr
        ddt_ctl_t               ctl;
        ddt_ctl_t               next_ctl;
        logic [3:0]             hi;
        logic [3:0]             next_hi;
        logic [7:0]             lo;
        logic [7:0]             next_lo;
        logic [`DDT_CNT_W-1:0]  cnt;
        logic [`DDT_CNT_W-1:0]  next_cnt;
        logic                   exp_c;

        always_comb
        begin
            next_ctl = ctl;
            next_hi  = hi;
            next_lo  = lo;
            next_cnt = cnt;
            exp_c    = 1'b0;
            if (ctl.enable && tick[i])
            begin
                if (cnt <= `DDT_CNT_ONE)
                begin
                    exp_c = 1'b1;
                    if (ctl.loop)
                        next_cnt = {hi, lo};
                    else
                    begin
                        next_cnt        = 12'h000;
                        next_ctl.enable = 1'b0;
                    end
                end
                else
                    next_cnt = cnt - `DDT_CNT_ONE;
            end
            if (wr_en && ddt_hit(paddr, IDX_HI[i]))
                next_hi = pwdata[3:0];
            if (wr_en && ddt_hit(paddr, IDX_LO[i]))
                next_lo = pwdata[7:0];
            // a start loads the programmed value; software write wins
            if (wr_en && ddt_hit(paddr, IDX_CTL[i]))
            begin
                next_ctl = ddt_ctl_t'(pwdata[7:0]);
                if (pwdata[7] && !ctl.enable)
                    next_cnt = {hi, lo};
            end
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                ctl <= ddt_ctl_t'(`DDT_CTL_RESET);
                hi  <= 4'h0;
                lo  <= 8'h00;
                cnt <= 12'h000;
            end
            else
            begin
                ctl <= next_ctl;
                hi  <= next_hi;
                lo  <= next_lo;
                cnt <= next_cnt;
            end
        end

        assign ctl_a[i]    = ctl;
        assign reload_a[i] = {hi, lo};
        assign cnt_a[i]    = cnt;
        assign expire[i]   = exp_c;
    end

    // ==========================================================
    // interrupt status, mask and wake events
    logic [1:0] status;
    logic [1:0] next_status;
    logic [1:0] mask;
    logic [1:0] next_mask;
    logic [1:0] clr;
    logic [1:0] wake_en;
    logic [1:0] rst_en;

    assign wake_en = {ctl_a[1].wake, ctl_a[0].wake};
    assign rst_en  = {ctl_a[1].wake_rst, ctl_a[0].wake_rst};

    always_comb
    begin
        clr       = 2'b00;
        next_mask = mask;
        if (wr_en && ddt_hit(paddr, `DDT_IDX_INT_STAT))
            clr = {pwdata[`DDT_INT_T2_BIT], pwdata[`DDT_INT_T1_BIT]};
        if (wr_en && ddt_hit(paddr, `DDT_IDX_INT_MASK))
            next_mask = {pwdata[`DDT_INT_T2_BIT], pwdata[`DDT_INT_T1_BIT]};
        // a new expiry beats a clear in the same cycle
        next_status = (status & ~clr) | expire;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status         <= 2'b00;
            mask           <= 2'b00;
            wakeup         <= 1'b0;
            wake_reset_req <= 1'b0;
            timer_one_out  <= 1'b0;
        end
        else
        begin
            status         <= next_status;
            mask           <= next_mask;
            wakeup         <= |(expire & wake_en);
            wake_reset_req <= |(expire & wake_en & rst_en);
            timer_one_out  <= expire[0];
        end
    end

    assign irq = |(status & mask);

    // ==========================================================
    // read data, captured in the setup cycle
    logic [31:0] next_prdata;
    logic        next_err;
    logic        err;
    logic [7:0]  rd;
    logic        hit_any;

    always_comb
    begin
        rd      = 8'h00;
        hit_any = 1'b1;
        if (ddt_hit(paddr, `DDT_IDX_T1_HIGH))
            rd = {4'h0, reload_a[0][11:8]};
        else if (ddt_hit(paddr, `DDT_IDX_T1_LOW))
            rd = reload_a[0][7:0];
        else if (ddt_hit(paddr, `DDT_IDX_T1_CTL))
            rd = ctl_a[0];
        else if (ddt_hit(paddr, `DDT_IDX_T2_HIGH))
            rd = {4'h0, reload_a[1][11:8]};
        else if (ddt_hit(paddr, `DDT_IDX_T2_LOW))
            rd = reload_a[1][7:0];
        else if (ddt_hit(paddr, `DDT_IDX_T2_CTL))
            rd = ctl_a[1];
        else if (ddt_hit(paddr, `DDT_IDX_INT_STAT))
            rd = {2'b00, status, 4'h0};
        else if (ddt_hit(paddr, `DDT_IDX_INT_MASK))
            rd = {2'b00, mask, 4'h0};
        else
            hit_any = 1'b0;
        next_prdata = prdata;
        next_err    = err;
        if (rd_setup)
        begin
            next_prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd};
            next_err    = ~hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            err    <= 1'b0;
        end
        else
        begin
            prdata <= next_prdata;
            err    <= next_err;
        end
    end

    assign pslverr = psel & penable & err;

    // ==========================================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_ONE_SHOT_STOP: assert property (expire[0] && !ctl_a[0].loop
        && !wr_en |=> !ctl_a[0].enable && cnt_a[0] == 12'h000)
        else $error("one-shot timer one did not stop");
    AST_LOOP_RELOAD: assert property (expire[0] && ctl_a[0].loop
        && !wr_en |=> ctl_a[0].enable && cnt_a[0] == $past(reload_a[0]))
        else $error("timer one loop did not reload");
    AST_T2_LOOP: assert property (expire[1] && ctl_a[1].loop
        && !wr_en |=> ctl_a[1].enable && cnt_a[1] == $past(reload_a[1]))
        else $error("timer two loop did not reload");
    AST_STOPPED: assert property (!ctl_a[0].enable && !wr_en
        |=> $stable(cnt_a[0]) && !expire[0])
        else $error("stopped timer one moved");
    AST_DEC: assert property (ctl_a[1].enable && tick[1]
        && cnt_a[1] > 12'h001 && !wr_en
        |=> cnt_a[1] == $past(cnt_a[1]) - 12'h001)
        else $error("timer two did not count down");
    AST_WAKE: assert property (expire[0] && ctl_a[0].wake |=> wakeup)
        else $error("timer one wake missing");
    AST_NO_WAKE: assert property (!(|(expire & wake_en)) |=> !wakeup)
        else $error("wake without enabled expiry");
    AST_RST: assert property (wake_reset_req |-> $past(expire[0]
        && wake_en[0] && rst_en[0]) || $past(expire[1] && wake_en[1]
        && rst_en[1]))
        else $error("wake reset without cause");
    AST_INT_SET: assert property (expire[1] |=> status[1]
        ##0 (irq == mask[1] || status[0]))
        else $error("timer two interrupt not set");
    AST_GND: assert property (ctl_a[0].src == DDT_SRC_ALT && !wr_en
        |=> $stable(cnt_a[0]))
        else $error("timer one counted on ground source");
    AST_CASCADE: assert property (ctl_a[1].src == DDT_SRC_ALT
        && !expire[0] && !wr_en |=> $stable(cnt_a[1]))
        else $error("cascaded timer two moved without timer one");
    AST_HI_READ: assert property (rd_setup && !pwrite
        && ddt_hit(paddr, `DDT_IDX_T1_HIGH)
        |=> prdata == {28'h0000000, $past(reload_a[0][11:8])})
        else $error("timer one high read wrong");

    COV_LOOP: cover property (expire[0] && ctl_a[0].loop);
    COV_CASCADE: cover property (expire[1] && ctl_a[1].src == DDT_SRC_ALT);
    COV_RESET_REQ: cover property (wake_reset_req);
    COV_IRQ: cover property (irq);

endmodule : ddt_timers

// ==== verif/tb_dual_down_count_timers.sv ====
// self-checking bench for the timer pair: apb registers, timers, interrupt
// assumes ddt_timers, ddt_pkg and the register indices of ddt_cfg.svh
`include "ddt_cfg.svh"

`define CHK(got, exp) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module tb_dual_down_count_timers
    import ddt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // signals
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        external_port_pin_zero;
    logic        external_port_pin_one;
    logic        user_divided_clock = 1'b0;
    logic        clk_32768          = 1'b0;
    logic [2:0]  div_cnt            = 3'h0;
    logic        irq;
    logic        wakeup;
    logic        wake_reset_req;
    logic        timer_one_out;
    int          err_count;
    int          total_checks;
    int          n_t1;
    int          n_wake;
    int          n_wrst;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    logic [31:0] rng;
    ddt_src_t    srcs[6];

    ddt_timers dut_u (
        .pclk                   (pclk),
        .presetn                (presetn),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .external_port_pin_zero (external_port_pin_zero),
        .external_port_pin_one  (external_port_pin_one),
        .user_divided_clock     (user_divided_clock),
        .clk_32768              (clk_32768),
        .irq                    (irq),
        .wakeup                 (wakeup),
        .wake_reset_req         (wake_reset_req),
        .timer_one_out          (timer_one_out)
    );

    // ==========================================================
    // clocks
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // slow sources are unrelated to pclk in rate only
    always @(posedge pclk)
    begin
        div_cnt <= div_cnt + 3'h1;
        if (div_cnt[0])
            user_divided_clock <= ~user_divided_clock;
        if (div_cnt[1:0] == 2'b11)
            clk_32768 <= ~clk_32768;
    end

    // ==========================================================
    // monitor: pops the oldest note at each completed access
    always @(posedge pclk)
    begin
        if (timer_one_out === 1'b1)
            n_t1++;
        if (wakeup === 1'b1)
            n_wake++;
        if (wake_reset_req === 1'b1)
            n_wrst++;
        if (presetn && psel && penable && pready === 1'b1)
        begin
            if (exp_q.size() == 0)
                `CHK(1'b1, 1'b0)
            else
            begin
                e = exp_q.pop_front();
                `CHK(pslverr, e[32])
                if (!e[33])
                    `CHK(prdata, e[31:0])
            end
        end
    end

    // ==========================================================
    // tasks
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    task automatic apb(input logic wr, input logic [15:0] idx,
                       input logic [7:0] wd, input logic [7:0] rd,
                       input logic err);
        int k;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {14'h0, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        exp_q.push_back({wr, err, 24'h0, rd});
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (k == 16)
        begin
            err_count++;
            summarize();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // pin edge is seen three pclk later through the synchronisers
    task automatic pin_tick(input bit which);
        @(posedge pclk);
        if (which)
            external_port_pin_one <= 1'b1;
        else
            external_port_pin_zero <= 1'b1;
        repeat (3) @(posedge pclk);
        external_port_pin_one  <= 1'b0;
        external_port_pin_zero <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask : pin_tick

    task automatic wait_wake(input int base, input int bound, input bit must);
        int k;
        for (k = 0; k < bound && n_wake == base; k++)
            @(posedge pclk);
        repeat (2) @(posedge pclk);
        if (must && n_wake == base)
        begin
            err_count++;
            summarize();
        end
    endtask : wait_wake

    // ==========================================================
    // main sequence
    initial
    begin
        int i;
        int t;
        int b;
        logic [15:0] ctl_idx;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {external_port_pin_zero, external_port_pin_one} = 2'b00;
        {err_count, total_checks, n_t1, n_wake, n_wrst} = '0;
        srcs = '{DDT_SRC_PIN, DDT_SRC_DIV2, DDT_SRC_DIV6, DDT_SRC_DIV10,
                 DDT_SRC_32K, DDT_SRC_ALT};
        rng = 32'h1aa6f70d;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `DDT_IDX_T1_CTL, 8'h00, 8'h00, 0);
        apb(0, `DDT_IDX_T2_CTL, 8'h00, 8'h00, 0);
        apb(0, `DDT_IDX_INT_STAT, 8'h00, 8'h00, 0);
        apb(0, `DDT_IDX_INT_MASK, 8'h00, 8'h00, 0);
        for (i = 0; i < 4; i++)
        begin
            rng = xs(rng);
            apb(1, `DDT_IDX_T1_HIGH, rng[7:0], 8'h00, 0);
            apb(1, `DDT_IDX_T1_LOW, rng[15:8], 8'h00, 0);
            apb(1, `DDT_IDX_T2_HIGH, rng[23:16], 8'h00, 0);
            apb(1, `DDT_IDX_T2_LOW, rng[31:24], 8'h00, 0);
            apb(0, `DDT_IDX_T1_HIGH, 8'h00, {4'h0, rng[3:0]}, 0);
            apb(0, `DDT_IDX_T1_LOW, 8'h00, rng[15:8], 0);
            apb(0, `DDT_IDX_T2_HIGH, 8'h00, {4'h0, rng[19:16]}, 0);
            apb(0, `DDT_IDX_T2_LOW, 8'h00, rng[31:24], 0);
            apb(1, `DDT_IDX_T1_CTL, {1'b0, rng[6:0]}, 8'h00, 0);
            apb(0, `DDT_IDX_T1_CTL, 8'h00, {1'b0, rng[6:0]}, 0);
            apb(1, `DDT_IDX_T2_CTL, {1'b0, rng[14:8]}, 8'h00, 0);
            apb(0, `DDT_IDX_T2_CTL, 8'h00, {1'b0, rng[14:8]}, 0);
        end
        // unmapped place: refused, write has no effect
        apb(1, 16'h1016, 8'hff, 8'h00, 1);
        apb(0, 16'h1016, 8'h00, 8'h00, 1);
        apb(1, `DDT_IDX_T2_CTL, 8'h00, 8'h00, 0);
        // one-shot from pin zero, count 2, wake without reset
        apb(1, `DDT_IDX_T1_HIGH, 8'h00, 8'h00, 0);
        apb(1, `DDT_IDX_T1_LOW, 8'h02, 8'h00, 0);
        apb(1, `DDT_IDX_T1_CTL, 8'hc0, 8'h00, 0);
        pin_tick(0);
        `CHK(n_t1, 0)
        pin_tick(0);
        `CHK(n_t1, 1)
        `CHK(n_wake, 1)
        `CHK(n_wrst, 0)
        apb(0, `DDT_IDX_T1_CTL, 8'h00, 8'h40, 0);
        apb(0, `DDT_IDX_INT_STAT, 8'h00, 8'h10, 0);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        apb(1, `DDT_IDX_INT_MASK, 8'h10, 8'h00, 0);
        @(negedge pclk);
        `CHK(irq, 1'b1)
        apb(1, `DDT_IDX_INT_STAT, 8'h10, 8'h00, 0);
        @(negedge pclk);
        `CHK(irq, 1'b0)
        pin_tick(0);
        `CHK(n_t1, 1)
        // loop timer one feeding one-shot timer two by cascade
        apb(1, `DDT_IDX_T1_LOW, 8'h01, 8'h00, 0);
        apb(1, `DDT_IDX_T2_HIGH, 8'h00, 8'h00, 0);
        apb(1, `DDT_IDX_T2_LOW, 8'h02, 8'h00, 0);
        apb(1, `DDT_IDX_T2_CTL, 8'he7, 8'h00, 0);
        apb(1, `DDT_IDX_T1_CTL, 8'h88, 8'h00, 0);
        pin_tick(0);
        pin_tick(0);
        pin_tick(0);
        `CHK(n_t1, 4)
        `CHK(n_wake, 2)
        `CHK(n_wrst, 1)
        apb(0, `DDT_IDX_T1_CTL, 8'h00, 8'h88, 0);
        apb(0, `DDT_IDX_T2_CTL, 8'h00, 8'h67, 0);
        apb(0, `DDT_IDX_INT_STAT, 8'h00, 8'h30, 0);
        apb(1, `DDT_IDX_T1_CTL, 8'h00, 8'h00, 0);
        apb(1, `DDT_IDX_INT_STAT, 8'h30, 8'h00, 0);
        apb(0, `DDT_IDX_INT_STAT, 8'h00, 8'h00, 0);
        // six sources of both timers (all but div16 and div14), count 1, wake counted
        apb(1, `DDT_IDX_T2_LOW, 8'h01, 8'h00, 0);
        for (t = 0; t < 2; t++)
        begin
            ctl_idx = t ? `DDT_IDX_T2_CTL : `DDT_IDX_T1_CTL;
            for (i = 0; i < 6; i++)
            begin
                b = n_wake;
                apb(1, ctl_idx, {5'b11000, srcs[i]}, 8'h00, 0);
                if (srcs[i] == DDT_SRC_PIN)
                    pin_tick(t[0]);
                wait_wake(b, (srcs[i] == DDT_SRC_ALT) ? 600 : 6000,
                          srcs[i] != DDT_SRC_ALT);
                `CHK(n_wake - b, (srcs[i] == DDT_SRC_ALT) ? 0 : 1)
                apb(1, ctl_idx, 8'h00, 8'h00, 0);
            end
        end
        // timer two looping on pin one: keeps running, expires each pass
        apb(1, `DDT_IDX_INT_STAT, 8'h30, 8'h00, 0);
        apb(1, `DDT_IDX_T2_CTL, 8'h88, 8'h00, 0);
        pin_tick(1);
        apb(0, `DDT_IDX_T2_CTL, 8'h00, 8'h88, 0);
        apb(0, `DDT_IDX_INT_STAT, 8'h00, 8'h20, 0);
        apb(1, `DDT_IDX_INT_STAT, 8'h20, 8'h00, 0);
        pin_tick(1);
        apb(0, `DDT_IDX_INT_STAT, 8'h00, 8'h20, 0);
        apb(1, `DDT_IDX_T2_CTL, 8'h00, 8'h00, 0);
        summarize();
    end

endmodule : tb_dual_down_count_timers
